// [hdl/fsw_pkg.sv]
`default_nettype none
package fsw_pkg;
   // Timing.
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned PUW_TIME_US = 1000;
   localparam int unsigned WRITE_TIME_US = 5000;
   localparam int unsigned PUW_CYCLES_DEF = PUW_TIME_US * CLK_MHZ;
   localparam int unsigned WRITE_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;
   localparam int TMR_W = 24;
   // Commands.
   localparam logic [7:0] CMD_WREN = 8'h06;
   localparam logic [7:0] CMD_VWREN = 8'h50;
   localparam logic [7:0] CMD_WRDI = 8'h04;
   localparam logic [7:0] CMD_WRSR = 8'h01;
   localparam logic [7:0] CMD_WRSR2 = 8'h31;
   localparam logic [7:0] CMD_WRSR3 = 8'h11;
   localparam logic [7:0] CMD_PP = 8'h02;
   localparam logic [7:0] CMD_SE = 8'h20;
   localparam logic [7:0] CMD_BE = 8'hD8;
   localparam logic [7:0] CMD_CE = 8'hC7;
   localparam logic [7:0] CMD_SUSP = 8'h75;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_DPD = 8'hB9;
   localparam logic [7:0] CMD_REL = 8'hAB;
   // Status field positions.
   localparam int SR1_BP_LO = 2;
   localparam int SR1_TB = 5;
   localparam int SR1_SEC = 6;
   localparam int SR1_SRP = 7;
   localparam int SR2_QE = 1;
   localparam int SR2_LB_LO = 3;
   localparam int SR2_CMP = 6;
   localparam int SR3_HFM = 4;
   localparam int SR3_DRV_LO = 5;
   localparam int SR3_PAUSE_OR_RESET_SELECT = 7;
   // Serial framing.
   localparam logic [2:0] BIT_ZERO = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [1:0] CNT_ZERO = 2'h0;
   localparam logic [1:0] CNT_ONE = 2'h1;
   localparam logic [1:0] CNT_TWO = 2'h2;
   localparam logic [1:0] CNT_FULL = 2'h3;
   // Drive strength in percent.
   localparam logic [6:0] DRV_PCT_00 = 7'h32;
   localparam logic [6:0] DRV_PCT_01 = 7'h19;
   localparam logic [6:0] DRV_PCT_10 = 7'h4B;
   localparam logic [6:0] DRV_PCT_11 = 7'h64;
   localparam logic [2:0] LOCK_NONE = 3'h0;

   typedef struct packed {
      logic srp;
      logic sec;
      logic tb;
      logic [2:0] bp;
      logic cmp;
      logic qe;
      logic pause_or_reset_select;
      logic [1:0] drv;
      logic high_freq_mode_bit;
   } fsw_cfg_t;

   localparam fsw_cfg_t CFG_DEFAULT = '0;

   typedef struct packed {
      logic [7:0] three;
      logic [7:0] two;
      logic [7:0] one;
   } fsw_status_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WRITE = 2'b01,
      ST_ARRAY = 2'b10,
      ST_SUSP = 2'b11
   } fsw_state_t;
endpackage
`default_nettype wire

// [hdl/fsw_status_protect.sv]
// Function
// (RULE_01) Protect bit clear: writes need only latch.
// (RULE_02) Protect set, pin low: status writes refused.
// (RULE_03) Protect set, pin high: writes after latch.
// (RULE_04) Busy, latch, suspend never written by software.
// (RULE_05) Locked writes leave configuration and locks unchanged.
// (RULE_06) Write enable then write hits non-volatile; the code leaves the drive field unchanged on such writes.
// (RULE_07) Volatile enable then write hits volatile copy.
// (RULE_08) Lock bits untouched by volatile status writes.
// (RULE_09) Suspend sets flag; resume or power clears.
// (RULE_10) Lock bits set once, never cleared.
// (RULE_11) Quad enable turns off protect, pause, reset.
// (RULE_12) Select bit picks pause or reset function.
// (RULE_13) Drive field maps to output strength percent.
// (RULE_14) High frequency bit defaults clear, enables mode.
// (RULE_15) Commands ending mid-byte are ignored.
// (RULE_16) Below power threshold nothing is recognised.
// (RULE_17) Write commands refused during power-up delay.
// (RULE_18) Latch starts clear; writes need it set.
// (RULE_19) Latch clears when a write operation ends.
// (RULE_20) Deep sleep ignores all but release command.
// (RULE_21) Busy ignores every command but status read; the code also takes suspend while an array operation is busy.
// (RULE_22) Complement bit inverts the protected region.
// (RULE_23) Program or erase into protection is ignored.
`timescale 1ns/1ns
`default_nettype none
module fsw_status_protect #(
   parameter int unsigned PUW_CYCLES = fsw_pkg::PUW_CYCLES_DEF,
   parameter int unsigned WRITE_CYCLES = fsw_pkg::WRITE_CYCLES_DEF
) (
   // System clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Serial link from the host.
   input wire logic spi_clk,
   input wire logic cs_n,
   input wire logic mosi,
   // Control pins.
   input wire logic wp_n,
   input wire logic hold_reset_n,
   input wire logic power_ok,
   // Array engine.
   input wire logic region_protected,
   input wire logic array_done,
   output logic array_start,
   output logic [7:0] array_op,
   output logic suspend_req,
   output logic resume_req,
   // Status and pin functions.
   output fsw_pkg::fsw_status_t status_out,
   output logic pause_active,
   output logic pin_reset_active,
   output logic quad_mode,
   output logic [6:0] drive_pct,
   output logic high_freq_active,
   output logic protect_invert,
   output logic deep_sleep_active
);
   import fsw_pkg::*;

   function automatic fsw_cfg_t cfg_write(input fsw_cfg_t c,
         input logic [7:0] cmd, input logic three,
         input logic [7:0] d1, input logic [7:0] d2, input logic vol);
      fsw_cfg_t r;
      logic [7:0] b2;
      r = c;
      b2 = (cmd == CMD_WRSR2) ? d1 : d2;
      if (cmd == CMD_WRSR) begin
         r.srp = d1[SR1_SRP];
         r.sec = d1[SR1_SEC];
         r.tb = d1[SR1_TB];
         r.bp = d1[SR1_BP_LO +: 3];
      end
      if (cmd == CMD_WRSR2 || (cmd == CMD_WRSR && three)) begin
         r.cmp = b2[SR2_CMP];
         r.qe = b2[SR2_QE];
      end
      if (cmd == CMD_WRSR3) begin
         r.pause_or_reset_select = d1[SR3_PAUSE_OR_RESET_SELECT];
         r.high_freq_mode_bit = d1[SR3_HFM];
         if (vol) begin
            r.drv = d1[SR3_DRV_LO +: 2];
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] lock_of(input logic [7:0] cmd,
         input logic three, input logic [7:0] d1, input logic [7:0] d2);
      logic [2:0] r;
      r = LOCK_NONE;
      if (cmd == CMD_WRSR2) begin
         r = d1[SR2_LB_LO +: 3];
      end else if (cmd == CMD_WRSR && three) begin
         r = d2[SR2_LB_LO +: 3];
      end
      return r;
   endfunction

   function automatic logic [6:0] pct_of(input logic [1:0] drv);
      logic [6:0] r;
      unique case (drv)
         2'b00: r = DRV_PCT_00;
         2'b01: r = DRV_PCT_01;
         2'b10: r = DRV_PCT_10;
         2'b11: r = DRV_PCT_11;
      endcase
      return r;
   endfunction

   // Link domain. The byte register holds for eight link clocks after
   // its toggle, which leaves the system side ample time to read it.
   logic [2:0] bit_cnt_reg;
   logic [6:0] shift_reg;
   logic [7:0] byte_reg;
   logic byte_tgl_reg;
   logic partial_reg;

   always_ff @(posedge spi_clk or posedge cs_n or posedge sys_rst) begin
      if (cs_n || sys_rst) begin
         bit_cnt_reg <= BIT_ZERO;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
   end

   // The partial flag is not cleared by chip select, so it still tells
   // after the frame whether the last byte was whole.
   always_ff @(posedge spi_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= 7'h00;
         byte_reg <= 8'h00;
         byte_tgl_reg <= 1'b0;
         partial_reg <= 1'b0;
      end else begin
         shift_reg <= {shift_reg[5:0], mosi};
         partial_reg <= (bit_cnt_reg != BIT_LAST); // [RULE_15]
         if (bit_cnt_reg == BIT_LAST) begin
            byte_reg <= {shift_reg, mosi};
            byte_tgl_reg <= ~byte_tgl_reg;
         end
      end
   end

   // Synchronisers. Chip select has one stage more, so the frame ends
   // only after its last byte has been taken.
   logic [3:0] cs_sync_reg;
   logic [2:0] tgl_sync_reg;
   logic [1:0] part_sync_reg;
   logic [1:0] wp_sync_reg;
   logic [1:0] hr_sync_reg;
   logic [1:0] pwr_sync_reg;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cs_sync_reg <= 4'hF;
         tgl_sync_reg <= 3'h0;
         part_sync_reg <= 2'h0;
         wp_sync_reg <= 2'h3;
         hr_sync_reg <= 2'h3;
         pwr_sync_reg <= 2'h0;
      end else begin
         cs_sync_reg <= {cs_sync_reg[2:0], cs_n};
         tgl_sync_reg <= {tgl_sync_reg[1:0], byte_tgl_reg};
         part_sync_reg <= {part_sync_reg[0], partial_reg};
         wp_sync_reg <= {wp_sync_reg[0], wp_n};
         hr_sync_reg <= {hr_sync_reg[0], hold_reset_n};
         pwr_sync_reg <= {pwr_sync_reg[0], power_ok};
      end
   end

   logic byte_evt;
   logic frame_end;
   assign byte_evt = tgl_sync_reg[1] ^ tgl_sync_reg[2];
   assign frame_end = cs_sync_reg[2] & ~cs_sync_reg[3];

   // Frame capture.
   logic [1:0] cnt_reg;
   logic [7:0] cmd_reg;
   logic [7:0] d1_reg;
   logic [7:0] d2_reg;

   always_ff @(posedge clock) begin
      if (sys_rst || frame_end) begin
         cnt_reg <= CNT_ZERO;
         cmd_reg <= 8'h00;
         d1_reg <= 8'h00;
         d2_reg <= 8'h00;
      end else if (byte_evt && cnt_reg != CNT_FULL) begin
         cnt_reg <= cnt_reg + CNT_ONE;
         if (cnt_reg == CNT_ZERO) begin
            cmd_reg <= byte_reg;
         end
         if (cnt_reg == CNT_ONE) begin
            d1_reg <= byte_reg;
         end
         if (cnt_reg == CNT_TWO) begin
            d2_reg <= byte_reg;
         end
      end
   end

   // Command decode.
   fsw_cfg_t nv_reg;
   fsw_cfg_t vol_reg;
   fsw_state_t state_reg;
   logic [2:0] lock_reg;
   logic wel_reg;
   logic vwel_reg;
   logic sus_reg;
   logic dpd_reg;
   logic puw_done_reg;
   logic [TMR_W-1:0] tmr_reg;
   logic [TMR_W-1:0] puw_cnt_reg;

   logic pwr_good;
   logic pin_rst;
   logic sr_locked;
   logic busy;
   logic cmd_ok;
   logic three;
   logic is_wr;
   logic is_arr;
   logic sw_ok;
   logic ar_ok;

   assign pwr_good = pwr_sync_reg[1];
   assign three = (cnt_reg == CNT_FULL);
   assign pin_rst = ~vol_reg.qe & vol_reg.pause_or_reset_select & ~hr_sync_reg[1]; // [RULE_12]
   // With quad enable set the protect pin reads as released. [RULE_11]
   assign sr_locked = vol_reg.srp & ~vol_reg.qe & ~wp_sync_reg[1]; // [RULE_02]
   assign busy = (state_reg == ST_WRITE) || (state_reg == ST_ARRAY);
   assign is_wr = (cmd_reg == CMD_WRSR) || (cmd_reg == CMD_WRSR2) ||
                  (cmd_reg == CMD_WRSR3);
   assign is_arr = (cmd_reg == CMD_PP) || (cmd_reg == CMD_SE) ||
                   (cmd_reg == CMD_BE) || (cmd_reg == CMD_CE);
   // Suspend is the one command let through while the array is busy.
   assign cmd_ok = frame_end && pwr_good && !pin_rst && // [RULE_16]
                   !part_sync_reg[1] && cnt_reg != CNT_ZERO && // [RULE_15]
                   (!dpd_reg || cmd_reg == CMD_REL) && // [RULE_20]
                   (!busy || (state_reg == ST_ARRAY &&
                              cmd_reg == CMD_SUSP)); // [RULE_21]
   assign sw_ok = cmd_ok && is_wr && cnt_reg != CNT_ONE &&
                  (wel_reg || vwel_reg) && puw_done_reg && // [RULE_18]
                  !sr_locked; // [RULE_01] [RULE_03] [RULE_05]
   assign ar_ok = cmd_ok && is_arr && wel_reg && puw_done_reg && // [RULE_17]
                  !region_protected && state_reg == ST_IDLE; // [RULE_23]

   // Power-up write lockout.
   always_ff @(posedge clock) begin
      if (sys_rst || !pwr_good) begin
         puw_cnt_reg <= '0;
         puw_done_reg <= 1'b0;
      end else if (!puw_done_reg) begin
         puw_cnt_reg <= puw_cnt_reg + 1'b1;
         puw_done_reg <= (puw_cnt_reg == TMR_W'(PUW_CYCLES - 1)); // [RULE_17]
      end
   end

   // Configuration copies and one-time locks.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         nv_reg <= CFG_DEFAULT;
         vol_reg <= CFG_DEFAULT; // [RULE_14]
         lock_reg <= LOCK_NONE; // [RULE_10]
      end else if (!pwr_good) begin
         vol_reg <= nv_reg;
      end else if (sw_ok && vwel_reg) begin
         vol_reg <= cfg_write(vol_reg, cmd_reg, three, d1_reg, d2_reg,
                              1'b1); // [RULE_07] [RULE_08]
      end else if (sw_ok) begin
         nv_reg <= cfg_write(nv_reg, cmd_reg, three, d1_reg, d2_reg,
                             1'b0); // [RULE_06]
         vol_reg <= cfg_write(vol_reg, cmd_reg, three, d1_reg, d2_reg,
                              1'b0);
         lock_reg <= lock_reg |
                     lock_of(cmd_reg, three, d1_reg, d2_reg); // [RULE_10]
      end
   end

   // Latches, suspend and deep sleep.
   always_ff @(posedge clock) begin
      if (sys_rst || !pwr_good || pin_rst) begin
         wel_reg <= 1'b0; // [RULE_18]
         vwel_reg <= 1'b0;
         sus_reg <= 1'b0; // [RULE_09]
         dpd_reg <= 1'b0;
      end else begin
         if (state_reg == ST_WRITE && tmr_reg == TMR_W'(WRITE_CYCLES - 1)) begin
            wel_reg <= 1'b0; // [RULE_19]
         end else if (state_reg == ST_ARRAY && array_done) begin
            wel_reg <= 1'b0; // [RULE_19]
         end else if (cmd_ok && cmd_reg == CMD_WRDI) begin
            wel_reg <= 1'b0;
         end else if (cmd_ok && cmd_reg == CMD_WREN && puw_done_reg) begin
            wel_reg <= 1'b1; // [RULE_17]
         end
         if (sw_ok || (cmd_ok && (cmd_reg == CMD_WRDI ||
                                  cmd_reg == CMD_WREN))) begin
            vwel_reg <= 1'b0;
         end else if (cmd_ok && cmd_reg == CMD_VWREN && puw_done_reg) begin
            vwel_reg <= 1'b1;
         end
         if (cmd_ok && cmd_reg == CMD_SUSP && state_reg == ST_ARRAY) begin
            sus_reg <= 1'b1; // [RULE_09]
         end else if (cmd_ok && cmd_reg == CMD_RESUME) begin
            sus_reg <= 1'b0; // [RULE_09]
         end
         if (cmd_ok && cmd_reg == CMD_DPD) begin
            dpd_reg <= 1'b1;
         end else if (cmd_ok && cmd_reg == CMD_REL) begin
            dpd_reg <= 1'b0; // [RULE_20]
         end
      end
   end

   // Operation sequencer.
   always_ff @(posedge clock) begin
      if (sys_rst || !pwr_good || pin_rst) begin
         state_reg <= ST_IDLE;
         tmr_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               tmr_reg <= '0;
               if (sw_ok && !vwel_reg) begin
                  state_reg <= ST_WRITE;
               end else if (ar_ok) begin
                  state_reg <= ST_ARRAY;
               end
            end
            ST_WRITE: begin
               tmr_reg <= tmr_reg + 1'b1;
               if (tmr_reg == TMR_W'(WRITE_CYCLES - 1)) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_ARRAY: begin
               if (array_done) begin
                  state_reg <= ST_IDLE;
               end else if (cmd_ok && cmd_reg == CMD_SUSP) begin
                  state_reg <= ST_SUSP;
               end
            end
            ST_SUSP: begin
               if (cmd_ok && cmd_reg == CMD_RESUME) begin
                  state_reg <= ST_ARRAY;
               end
            end
         endcase
      end
   end

   // Outputs, all registered.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         array_start <= 1'b0;
         array_op <= 8'h00;
         suspend_req <= 1'b0;
         resume_req <= 1'b0;
      end else begin
         array_start <= ar_ok;
         if (ar_ok) begin
            array_op <= cmd_reg;
         end
         suspend_req <= cmd_ok && cmd_reg == CMD_SUSP &&
                        state_reg == ST_ARRAY && !array_done;
         resume_req <= cmd_ok && cmd_reg == CMD_RESUME &&
                       state_reg == ST_SUSP;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         status_out <= '0;
         pause_active <= 1'b0;
         pin_reset_active <= 1'b0;
         quad_mode <= 1'b0;
         drive_pct <= DRV_PCT_00;
         high_freq_active <= 1'b0;
         protect_invert <= 1'b0;
         deep_sleep_active <= 1'b0;
      end else begin
         status_out.one <= {vol_reg.srp, vol_reg.sec, vol_reg.tb, vol_reg.bp,
                            wel_reg, busy}; // [RULE_04]
         status_out.two <= {sus_reg, vol_reg.cmp, lock_reg, 1'b0,
                            vol_reg.qe, 1'b0}; // [RULE_04]
         status_out.three <= {vol_reg.pause_or_reset_select, vol_reg.drv, vol_reg.high_freq_mode_bit, 4'h0};
         pause_active <= ~vol_reg.qe & ~vol_reg.pause_or_reset_select &
                         ~hr_sync_reg[1]; // [RULE_11] [RULE_12]
         pin_reset_active <= pin_rst; // [RULE_12]
         quad_mode <= vol_reg.qe; // [RULE_11]
         drive_pct <= pct_of(vol_reg.drv); // [RULE_13]
         high_freq_active <= vol_reg.high_freq_mode_bit; // [RULE_14]
         protect_invert <= vol_reg.cmp; // [RULE_22]
         deep_sleep_active <= dpd_reg;
      end
   end

   sequence s_suspend_taken;
      cmd_ok && cmd_reg == CMD_SUSP && state_reg == ST_ARRAY && !array_done;
   endsequence

   property p_lock_hold;
      @(posedge clock) disable iff (sys_rst)
      frame_end && sr_locked && pwr_good |=> $stable(nv_reg) &&
         $stable(vol_reg) && $stable(lock_reg);
   endproperty
   a_lock_hold: assert property (p_lock_hold) // [RULE_05]
      else $error("locked status write changed configuration");

   property p_soft_write;
      @(posedge clock) disable iff (sys_rst)
      cmd_ok && cmd_reg == CMD_WRSR && cnt_reg != CNT_ONE && wel_reg &&
         !vwel_reg && puw_done_reg && !vol_reg.srp |=>
         state_reg == ST_WRITE;
   endproperty
   a_soft_write: assert property (p_soft_write) // [RULE_01]
      else $error("unprotected status write not started");

   property p_vol_no_lock;
      @(posedge clock) disable iff (sys_rst)
      sw_ok && vwel_reg |=> $stable(lock_reg) && $stable(nv_reg) &&
         state_reg == ST_IDLE;
   endproperty
   a_vol_no_lock: assert property (p_vol_no_lock) // [RULE_08]
      else $error("volatile write touched non-volatile state");

   property p_otp;
      @(posedge clock) disable iff (sys_rst)
      ##1 ($past(lock_reg) & ~lock_reg) == LOCK_NONE;
   endproperty
   a_otp: assert property (p_otp) // [RULE_10]
      else $error("security lock bit cleared");

   property p_wel_end;
      @(posedge clock) disable iff (sys_rst)
      busy ##1 state_reg == ST_IDLE |-> !wel_reg;
   endproperty
   a_wel_end: assert property (p_wel_end) // [RULE_19]
      else $error("latch still set after operation end");

   property p_puw;
      @(posedge clock) disable iff (sys_rst)
      !puw_done_reg && !wel_reg |=> !wel_reg;
   endproperty
   a_puw: assert property (p_puw) // [RULE_17]
      else $error("latch set during power-up delay");

   property p_dpd;
      @(posedge clock) disable iff (sys_rst)
      dpd_reg && pwr_good && !pin_rst && cmd_reg != CMD_REL ##1
         dpd_reg |-> $stable(wel_reg) && $stable(state_reg);
   endproperty
   a_dpd: assert property (p_dpd) // [RULE_20]
      else $error("command acted in deep sleep");

   property p_partial;
      @(posedge clock) disable iff (sys_rst)
      frame_end && part_sync_reg[1] && !busy && pwr_good && !pin_rst |=>
         $stable(nv_reg) &&
         $stable(state_reg) && !array_start;
   endproperty
   a_partial: assert property (p_partial) // [RULE_15]
      else $error("mid-byte command executed");

   property p_drive;
      @(posedge clock) disable iff (sys_rst)
      1'b1 |=> drive_pct == pct_of($past(vol_reg.drv));
   endproperty
   a_drive: assert property (p_drive) // [RULE_13]
      else $error("drive percent mismatch");

   property p_suspend;
      @(posedge clock) disable iff (sys_rst)
      s_suspend_taken |=> sus_reg && suspend_req && state_reg == ST_SUSP;
   endproperty
   a_suspend: assert property (p_suspend) // [RULE_09]
      else $error("suspend not taken");

   property p_power;
      @(posedge clock) disable iff (sys_rst)
      !pwr_good |=> !wel_reg && !sus_reg && state_reg == ST_IDLE;
   endproperty
   a_power: assert property (p_power) // [RULE_16]
      else $error("state kept below power threshold");
endmodule
`default_nettype wire

// [sim/flash_status_write_protect_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module flash_status_write_protect_tb;
   import fsw_pkg::*;
   logic clock, sys_rst, wp_n, hold_reset_n, power_ok;
   logic region_protected, array_done, spi_clk, cs_n, mosi;
   logic array_start, suspend_req, resume_req, pause_active;
   logic pin_reset_active, quad_mode, high_freq_active, protect_invert;
   logic deep_sleep_active;
   logic [7:0] array_op;
   logic [6:0] drive_pct;
   fsw_status_t status_out;
   int err_total, n_tests, n_start, n_susp, n_res;
   logic [6:0] pct [4] = '{7'h32, 7'h19, 7'h4B, 7'h64};

   // Short counts keep the run brief; expectations use the same values.
   fsw_status_protect #(.PUW_CYCLES(40), .WRITE_CYCLES(60)) DUT (
      .clock(clock), .sys_rst(sys_rst), .spi_clk(spi_clk), .cs_n(cs_n),
      .mosi(mosi), .wp_n(wp_n), .hold_reset_n(hold_reset_n),
      .power_ok(power_ok), .region_protected(region_protected),
      .array_done(array_done), .array_start(array_start),
      .array_op(array_op), .suspend_req(suspend_req),
      .resume_req(resume_req), .status_out(status_out),
      .pause_active(pause_active), .pin_reset_active(pin_reset_active),
      .quad_mode(quad_mode), .drive_pct(drive_pct),
      .high_freq_active(high_freq_active),
      .protect_invert(protect_invert),
      .deep_sleep_active(deep_sleep_active));
   fsw_host host (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      n_start += (array_start === 1'b1);
      n_susp += (suspend_req === 1'b1);
      n_res += (resume_req === 1'b1);
   end

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tx(input logic [23:0] f, input int n = 8);
      host.send(f, n);
      @(negedge clock);
   endtask
   task automatic wait_idle();
      for (int k = 0; status_out.one[0] !== 1'b0; k++) begin
         if (k > 200) begin
            err_total++;
            final_report();
         end
         @(negedge clock);
      end
   endtask
   task automatic pins(input logic w, input logic h, input logic p);
      @(posedge clock);
      wp_n <= w;
      hold_reset_n <= h;
      power_ok <= p;
      repeat (6) @(negedge clock);
   endtask

   task automatic t_reset();
      chk(status_out.one, 8'h00);
      chk(status_out.two, 8'h00);
      chk({1'b0, drive_pct}, 8'h32);
      chk({7'h00, high_freq_active}, 8'h00);
      tx(24'h060000);
      chk(status_out.one, 8'h00);
      repeat (40) @(negedge clock);
   endtask
   task automatic t_nv_write();
      tx(24'h060000);
      chk(status_out.one, 8'h02);
      tx(24'h019F40, 24);
      chk({7'h00, status_out.one[0]}, 8'h01);
      tx(24'hB90000);
      chk({7'h00, deep_sleep_active}, 8'h00);
      wait_idle();
      chk(status_out.one, 8'h9C);
      chk(status_out.two, 8'h40);
      chk({7'h00, protect_invert}, 8'h01);
   endtask
   task automatic t_locked();
      tx(24'h060000);
      tx(24'h010000, 24);
      wait_idle();
      chk(status_out.one, 8'h9E);
      chk(status_out.two, 8'h40);
      tx(24'h040000);
   endtask
   task automatic t_unlocked();
      pins(1'b1, 1'b1, 1'b1);
      tx(24'h060000);
      tx(24'h314800, 16);
      wait_idle();
      chk(status_out.two, 8'h48);
      chk(status_out.one, 8'h9C);
      tx(24'h060000);
      tx(24'h314000, 16);
      wait_idle();
      chk(status_out.two, 8'h48);
   endtask
   task automatic t_volatile();
      for (int d = 0; d < 4; d++) begin
         tx(24'h500000);
         tx({8'h11, 1'b0, d[1:0], 1'b1, 12'h000}, 16);
         chk({1'b0, drive_pct}, {1'b0, pct[d]});
         chk({7'h00, high_freq_active}, 8'h01);
         chk(status_out.one, 8'h9C);
      end
      tx(24'h500000);
      tx(24'h310000, 16);
      chk(status_out.two, 8'h08);
   endtask
   task automatic t_midbyte();
      tx(24'h060000, 15);
      chk(status_out.one, 8'h9C);
   endtask
   task automatic t_array();
      @(posedge clock);
      region_protected <= 1'b1;
      tx(24'h060000);
      tx(24'h200000);
      chk(n_start[7:0], 8'h00);
      @(posedge clock);
      region_protected <= 1'b0;
      tx(24'h020000);
      chk(n_start[7:0], 8'h01);
      chk(array_op, 8'h02);
      tx(24'h750000);
      chk({n_susp[6:0], status_out.two[7]}, 8'h03);
      tx(24'h7A0000);
      chk({n_res[6:0], status_out.two[7]}, 8'h02);
      @(posedge clock);
      array_done <= 1'b1;
      @(posedge clock);
      array_done <= 1'b0;
      repeat (4) @(negedge clock);
      chk(status_out.one, 8'h9C);
   endtask
   task automatic t_deep();
      tx(24'hB90000);
      tx(24'h060000);
      chk({deep_sleep_active, status_out.one[6:0]}, 8'h9C);
      tx(24'hAB0000);
      chk({7'h00, deep_sleep_active}, 8'h00);
   endtask
   task automatic t_pins();
      pins(1'b1, 1'b0, 1'b1);
      chk({pause_active, pin_reset_active}, 8'h02);
      pins(1'b1, 1'b1, 1'b1);
      tx(24'h500000);
      tx(24'h118000, 16);
      pins(1'b1, 1'b0, 1'b1);
      chk({pause_active, pin_reset_active}, 8'h01);
      pins(1'b1, 1'b1, 1'b1);
      tx(24'h500000);
      tx(24'h310200, 16);
      pins(1'b0, 1'b0, 1'b1);
      chk({quad_mode, pause_active, pin_reset_active}, 8'h04);
      tx(24'h500000);
      tx(24'h110000, 16);
      chk(status_out.three, 8'h00);
   endtask
   task automatic t_power();
      pins(1'b1, 1'b1, 1'b0);
      tx(24'h060000);
      pins(1'b1, 1'b1, 1'b1);
      chk({6'h00, status_out.one[1:0]}, 8'h00);
   endtask

   initial begin
      {err_total, n_tests, n_start, n_susp, n_res} = '0;
      sys_rst = 1'b1;
      wp_n = 1'b0;
      hold_reset_n = 1'b1;
      power_ok = 1'b1;
      region_protected = 1'b0;
      array_done = 1'b0;
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      t_reset();
      t_nv_write();
      t_locked();
      t_unlocked();
      t_volatile();
      t_midbyte();
      t_array();
      t_deep();
      t_pins();
      t_power();
      final_report();
   end
   // A hung handshake must still end the run with a verdict.
   initial begin
      #3000000;
      err_total++;
      final_report();
   end
endmodule
`default_nettype wire

// [sim/fsw_host.sv]
`timescale 1ns/1ns
`default_nettype none
module fsw_host (
   // Link pins.
   output logic spi_clk,
   output logic cs_n,
   output logic mosi
);
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Sends the first nbits of data, MSB first, in SPI mode 0.
   // The clock stands still between frames and the data line is inverted
   // once the device is deselected, so stale bits are never seen as valid.
   task automatic send(input logic [23:0] data, input int nbits);
      #7;
      cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         mosi = data[23 - i];
         #32 spi_clk = 1'b1;
         #32 spi_clk = 1'b0;
      end
      #32 cs_n = 1'b1;
      mosi = ~mosi;
      #400;
   endtask
endmodule
`default_nettype wire
